// >>> core/ssp_pkg.sv
// constants, register map and shared types of the sync select block
// assumes one 100 mhz clock and an ahb-lite master in the same domain
package ssp_pkg;

  // timing
  localparam int unsigned SYS_CLK_HZ = 100_000_000;
  localparam int unsigned SEP_CLK_HZ = 5_000_000;
  localparam int unsigned SEP_DIV = SYS_CLK_HZ / SEP_CLK_HZ;
  localparam int unsigned DIV_W = 5;
  localparam logic [DIV_W-1:0] DIV_ZERO = 5'h00;
  localparam logic [DIV_W-1:0] DIV_ONE = 5'h01;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SEP_DIV - 1);

  // separator counter
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_SYNC_A = 8'h0e;
  localparam logic [7:0] IDX_SYNC_B = 8'h0f;
  localparam logic [7:0] IDX_TRIG = 8'h11;
  localparam logic [7:0] IDX_POL = 8'h12;
  localparam logic [7:0] IDX_STAT = 8'h13;
  localparam logic [7:0] IDX_NONE = 8'hff;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_MSB = 9;

  // field positions
  localparam int unsigned BIT_SOG_SEL = 3;
  localparam int unsigned BIT_SEP_SEL = 0;
  localparam int unsigned BIT_HOLD_SEL = 5;
  localparam int unsigned BIT_POL_HIGH = 0;
  localparam int unsigned STAT_DET = 0;
  localparam int unsigned STAT_HS = 1;
  localparam int unsigned STAT_HOLD = 2;
  localparam int unsigned STAT_VS = 3;
  localparam int unsigned STAT_CNT_LSB = 8;
  localparam int unsigned STAT_CNT_MSB = 15;

  // reset values and ahb-lite codes
  localparam logic [7:0] SYNC_A_RST = 8'h00;
  localparam logic [7:0] SYNC_B_RST = 8'h00;
  localparam logic [7:0] TRIG_RST = 8'h40;
  localparam logic [7:0] POL_RST = 8'h01;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam int unsigned HTRANS_ACT = 1;

  typedef enum logic [0:0] {SEP_SEEK, SEP_HOLD} ssp_sep_state_type;

endpackage

// >>> core/ssp_separator.sv
// vertical sync separator counter
// assumes a one-cycle step strobe and an already polarity-normalised input
`timescale 1ns/1ps
module ssp_separator
  import ssp_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // step strobe and sync level
  input wire logic tick_in,
  input wire logic active_in,
  input wire logic [CNT_W-1:0] trig_in,
  // result
  output logic det_out,
  output logic [CNT_W-1:0] cnt_out
);

  typedef struct packed {
    ssp_sep_state_type st;
    logic [CNT_W-1:0] cnt;
  } ssp_sep_reg_type;

  ssp_sep_reg_type r;
  ssp_sep_reg_type nxt;
  logic step;

  assign step = ce_in && tick_in;

  // counter only moves on the slow step strobe
  always_comb begin
    nxt = r;
    if (step) begin
      case (r.st)
        SEP_SEEK: begin
          if (r.cnt > trig_in) begin
            nxt.st = SEP_HOLD;
            nxt.cnt = CNT_ZERO;
          end else if (active_in) begin
            if (r.cnt != CNT_MAX) begin
              nxt.cnt = r.cnt + CNT_ONE;
            end
          end else if (r.cnt != CNT_ZERO) begin
            nxt.cnt = r.cnt - CNT_ONE;
          end
        end
        SEP_HOLD: begin
          if (r.cnt >= trig_in) begin
            nxt.st = SEP_SEEK;
            nxt.cnt = CNT_ZERO;
          end else if (!active_in) begin
            if (r.cnt != CNT_MAX) begin
              nxt.cnt = r.cnt + CNT_ONE;
            end
          end else if (r.cnt != CNT_ZERO) begin
            // serration pulses give back what absence earned
            nxt.cnt = r.cnt - CNT_ONE;
          end
        end
        default: begin
          nxt.st = SEP_SEEK;
          nxt.cnt = CNT_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '{st: SEP_SEEK, cnt: CNT_ZERO};
    end else begin
      r <= nxt;
    end
  end

  assign det_out = (r.st == SEP_HOLD);
  assign cnt_out = r.cnt;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_frozen_between: assert property (
    !step |=> $stable(r)) else $error("separator moved without step");
  a_seek_up: assert property (
    step && r.st == SEP_SEEK && active_in && r.cnt <= trig_in &&
    r.cnt != CNT_MAX |=> r.cnt == $past(r.cnt) + CNT_ONE)
    else $error("seek count did not rise");
  a_seek_down: assert property (
    step && r.st == SEP_SEEK && !active_in && r.cnt <= trig_in |=>
    r.cnt == (($past(r.cnt) == CNT_ZERO) ? CNT_ZERO :
    $past(r.cnt) - CNT_ONE)) else $error("seek count did not fall");
  a_sat_top: assert property (
    step && r.st == SEP_SEEK && active_in && r.cnt == CNT_MAX &&
    trig_in == CNT_MAX |=> r.cnt == CNT_MAX)
    else $error("counter wrapped");
  a_detect_clear: assert property (
    step && r.st == SEP_SEEK && r.cnt > trig_in |=>
    det_out && r.cnt == CNT_ZERO) else $error("vsync not declared");
  a_hold_up: assert property (
    step && r.st == SEP_HOLD && !active_in && r.cnt < trig_in |=>
    det_out && r.cnt == $past(r.cnt) + CNT_ONE)
    else $error("absence count did not rise");
  a_release_clear: assert property (
    step && r.st == SEP_HOLD && r.cnt >= trig_in |=>
    !det_out && r.cnt == CNT_ZERO) else $error("vsync not released");

endmodule

// >>> core/ssp_top.sv
// sync source selection, separator step divider and ahb-lite registers
// assumes sync inputs already synchronous to clk_in; bus idle while ce low
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ssp_top
  import ssp_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // sync sources
  input wire logic hsync_in,
  input wire logic green_embedded_sync_input,
  input wire logic coast_in,
  input wire logic vsync_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // selected syncs
  output logic hsync_out,
  output logic pll_ref_out,
  output logic pll_hold_out,
  output logic vsync_out,
  output logic sep_vsync_out
);

  typedef struct packed {
    logic [7:0] sync_a;
    logic [7:0] sync_b;
    logic [7:0] trig;
    logic [7:0] pol;
    logic [DIV_W-1:0] div;
    logic tick;
    logic active;
    logic hs;
    logic hold;
    logic vs;
    logic sep;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
  } ssp_top_reg_type;

  ssp_top_reg_type r;
  ssp_top_reg_type nxt;
  logic sep_det;
  logic [CNT_W-1:0] sep_cnt;
  logic accept;
  logic [7:0] addr_idx;
  logic [7:0] wr_idx;

  // an address outside the map decodes to no register
  function automatic logic [7:0] reg_index(input logic [31:0] addr);
    logic [7:0] idx;
    idx = addr[IDX_MSB:IDX_LSB];
    if (addr[31:IDX_MSB+1] != '0 || addr[IDX_LSB-1:0] != '0) begin
      idx = IDX_NONE;
    end
    return idx;
  endfunction

  function automatic logic pick(input logic sel, input logic one,
                                input logic zero);
    return sel ? one : zero;
  endfunction

  assign accept = hsel_in && hready_in && htrans_in[HTRANS_ACT];
  assign addr_idx = reg_index(haddr_in);
  assign wr_idx = r.wr_idx;

  ssp_separator u_sep (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .tick_in(r.tick),
    .active_in(r.active),
    .trig_in(r.trig),
    .det_out(sep_det),
    .cnt_out(sep_cnt)
  );

  always_comb begin
    logic cs;
    logic vsel;
    cs = 1'b0;
    vsel = 1'b0;
    nxt = r;
    if (ce_in) begin
      // data phase of a write; hwdata only valid now
      if (r.wr_pend) begin
        case (wr_idx)
          IDX_SYNC_A: nxt.sync_a = hwdata_in[7:0];
          IDX_SYNC_B: nxt.sync_b = hwdata_in[7:0];
          IDX_TRIG: nxt.trig = hwdata_in[7:0];
          IDX_POL: nxt.pol = hwdata_in[7:0];
          default: nxt.sync_a = nxt.sync_a;
        endcase
      end
      nxt.wr_pend = accept && hwrite_in;
      nxt.wr_idx = addr_idx;
      // read data built from post-write values so a read right after a
      // write sees the new value with no wait state
      if (accept && !hwrite_in) begin
        nxt.rdata = WORD_ZERO;
        case (addr_idx)
          IDX_SYNC_A: nxt.rdata[7:0] = nxt.sync_a;
          IDX_SYNC_B: nxt.rdata[7:0] = nxt.sync_b;
          IDX_TRIG: nxt.rdata[7:0] = nxt.trig;
          IDX_POL: nxt.rdata[7:0] = nxt.pol;
          IDX_STAT: begin
            nxt.rdata[STAT_DET] = sep_det;
            nxt.rdata[STAT_HS] = r.hs;
            nxt.rdata[STAT_HOLD] = r.hold;
            nxt.rdata[STAT_VS] = r.vs;
            nxt.rdata[STAT_CNT_MSB:STAT_CNT_LSB] = sep_cnt;
          end
          default: nxt.rdata = WORD_ZERO;
        endcase
      end
      // slow step strobe for the separator
      if (r.div == DIV_LAST) begin
        nxt.div = DIV_ZERO;
        nxt.tick = 1'b1;
      end else begin
        nxt.div = r.div + DIV_ONE;
        nxt.tick = 1'b0;
      end
      // muxes 1 and 2: composite sync source
      cs = pick(r.sync_a[BIT_SOG_SEL], green_embedded_sync_input,
                hsync_in);
      nxt.hs = cs;
      // polarity is settled here so the separator sees active-high only
      nxt.active = pick(r.pol[BIT_POL_HIGH], cs, ~cs);
      // mux 4: vertical sync source
      vsel = pick(r.sync_a[BIT_SEP_SEL], sep_det, vsync_in);
      nxt.vs = vsel;
      // mux 3: pll hold source
      nxt.hold = pick(r.sync_b[BIT_HOLD_SEL], vsel, coast_in);
      nxt.sep = sep_det;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '{sync_a: SYNC_A_RST, sync_b: SYNC_B_RST, trig: TRIG_RST,
             pol: POL_RST, div: DIV_ZERO, wr_idx: IDX_NONE,
             rdata: WORD_ZERO, default: 1'b0};
    end else begin
      r <= nxt;
    end
  end

  // only zero-wait okay answers; outputs are all flop fields
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hreadyout_out <= 1'b0;
      hresp_out <= HRESP_OKAY[0];
    end else if (ce_in) begin
      // ready rises on the first enabled cycle and then holds, so a frozen block keeps showing ready
      hreadyout_out <= 1'b1;
      hresp_out <= HRESP_OKAY[0];
    end
  end

  assign hrdata_out = r.rdata;
  assign hsync_out = r.hs;
  assign pll_ref_out = r.hs;
  assign pll_hold_out = r.hold;
  assign vsync_out = r.vs;
  assign sep_vsync_out = r.sep;

  sequence s_trig_addr;
    ce_in && accept && hwrite_in && addr_idx == IDX_TRIG;
  endsequence

  sequence s_trig_data;
    ce_in ##0 r.wr_pend;
  endsequence

  a_trig_write: assert property (
    @(posedge clk_in) disable iff (rst_in)
    s_trig_addr ##1 s_trig_data |=> r.trig == $past(hwdata_in[7:0]))
    else $error("trigger write lost");

  a_hs_mux: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in |=> hsync_out == ($past(r.sync_a[BIT_SOG_SEL]) ?
    $past(green_embedded_sync_input) : $past(hsync_in)))
    else $error("wrong horizontal sync source");

  a_ref_mux: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in |=> pll_ref_out == ($past(r.sync_a[BIT_SOG_SEL]) ?
    $past(green_embedded_sync_input) : $past(hsync_in)))
    else $error("wrong pll reference source");

  a_hold_mux: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in && !r.sync_b[BIT_HOLD_SEL] |=> pll_hold_out == $past(coast_in))
    else $error("wrong pll hold source");

  a_hold_vs: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in && r.sync_b[BIT_HOLD_SEL] |=> pll_hold_out == vsync_out)
    else $error("pll hold not from vertical sync");

  a_vs_mux: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in |=> vsync_out == ($past(r.sync_a[BIT_SEP_SEL]) ?
    $past(sep_det) : $past(vsync_in)))
    else $error("wrong vertical sync source");

  a_sep_mirror: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in |=> sep_vsync_out == $past(sep_det))
    else $error("separator output not mirrored");

  a_tick_period: assert property (
    @(posedge clk_in) disable iff (rst_in)
    r.tick && ce_in |=> !r.tick)
    else $error("step strobe too long");

  a_tick_rate: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in && r.div == DIV_LAST |=> r.tick && r.div == DIV_ZERO)
    else $error("step strobe missing");

  a_tick_restart: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in && r.tick |=> r.div == DIV_ONE)
    else $error("divider did not restart");

  a_pol_norm: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in |=> r.active == ($past(r.pol[BIT_POL_HIGH]) ?
    r.hs : !r.hs))
    else $error("separator input not normalised");

  a_write_sync_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in && r.wr_pend && r.wr_idx == IDX_SYNC_A |=>
    r.sync_a == $past(hwdata_in[7:0]))
    else $error("select write lost");

  a_write_sync_b: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in && r.wr_pend && r.wr_idx == IDX_SYNC_B |=>
    r.sync_b == $past(hwdata_in[7:0]))
    else $error("hold select write lost");

  a_write_pol: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in && r.wr_pend && r.wr_idx == IDX_POL |=>
    r.pol == $past(hwdata_in[7:0]))
    else $error("polarity write lost");

  a_stat_ro: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in && r.wr_pend && r.wr_idx == IDX_STAT |=>
    r.sync_a == $past(r.sync_a) && r.trig == $past(r.trig))
    else $error("status write changed a register");

  a_read_trig: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in && accept && !hwrite_in && addr_idx == IDX_TRIG && !r.wr_pend
    |=> hrdata_out[7:0] == $past(r.trig))
    else $error("trigger read wrong");

  a_stat_det: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in && accept && !hwrite_in && addr_idx == IDX_STAT |=>
    hrdata_out[STAT_DET] == $past(sep_det))
    else $error("status detect bit wrong");

  a_stat_cnt: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in && accept && !hwrite_in && addr_idx == IDX_STAT |=>
    hrdata_out[STAT_CNT_MSB:STAT_CNT_LSB] == $past(sep_cnt))
    else $error("status count wrong");

  a_ce_freeze: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !ce_in |=> $stable(r))
    else $error("state moved while disabled");

  a_ready_up: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in |=> hreadyout_out)
    else $error("slave not ready");

  a_resp_okay: assert property (
    @(posedge clk_in) disable iff (rst_in)
    hresp_out == HRESP_OKAY[0])
    else $error("response not okay");

  a_read_unmapped: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && accept && !hwrite_in && addr_idx == IDX_NONE |=>
    hrdata_out == WORD_ZERO) else $error("unmapped read not zero");

endmodule

// >>> verification/ssp_sync_src.sv
// graphics source model: repeating composite sync pulse train
// assumes go_in is held steady; out of a train the line stands at idle_lvl_in
`timescale 1ns/1ps
module ssp_sync_src (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // train control
  input wire logic go_in,
  input wire logic idle_lvl_in,
  input wire logic [15:0] act_len_in,
  input wire logic [15:0] idle_len_in,
  // composite sync, active high
  output logic csync_out
);
  logic [15:0] cnt_r;
  logic act_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in || !go_in) begin
      cnt_r <= 16'h0000;
      act_r <= 1'b1;
    end else if (cnt_r == (act_r ? act_len_in : idle_len_in) - 16'h0001) begin
      cnt_r <= 16'h0000;
      act_r <= !act_r;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
  // stands at the commanded level between trains, never a stale value
  assign csync_out = go_in ? act_r : idle_lvl_in;
endmodule

// >>> verification/ssp_top_tb.sv
// self-checking bench of the sync select block
// assumes the ahb-lite slave is alone on its bus, hready tied back
`timescale 1ns/1ps
module ssp_top_tb;
  import ssp_pkg::*;
  logic clk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1;
  logic hsync_in = 1'b0, coast_in = 1'b0, vsync_in = 1'b0, sog;
  logic go = 1'b0, lvl = 1'b0;
  logic hsel_in = 1'b0, hwrite_in = 1'b0, hreadyout_out, hresp_out;
  logic [1:0] htrans_in = 2'h0;
  logic [2:0] hsize_in = 3'h2;
  logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, rd;
  logic hsync_out, pll_ref_out, pll_hold_out, vsync_out, sep_vsync_out;
  int error_cnt = 0, n_compared = 0, n;
  typedef struct {logic [7:0] a, b; logic [3:0] inp, exp;} ssp_row_type;
  // inp = {hsync, green, coast, vsync}; exp = {hsync, ref, hold, vsync}
  ssp_row_type rows [4] = '{'{8'h00, 8'h00, 4'h8, 4'hc},
    '{8'h08, 8'h00, 4'ha, 4'h2}, '{8'h08, 8'h20, 4'h6, 4'hc},
    '{8'h00, 8'h20, 4'h5, 4'h3}};
  initial forever #5 clk_in = !clk_in;
  ssp_sync_src u_ssp_sync_src (.clk_in(clk_in), .rst_in(rst_in), .go_in(go),
    .idle_lvl_in(lvl), .act_len_in(16'd40), .idle_len_in(16'd400),
    .csync_out(sog));
  ssp_top u_ssp_top (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .hsync_in(hsync_in), .green_embedded_sync_input(sog),
    .coast_in(coast_in), .vsync_in(vsync_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
    .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .hsync_out(hsync_out), .pll_ref_out(pll_ref_out),
    .pll_hold_out(pll_hold_out), .vsync_out(vsync_out),
    .sep_vsync_out(sep_vsync_out));
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one edge per phase; a slave that never answers ends the run
  task automatic wait_rdy();
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_in);
      if (hreadyout_out === 1'b1) return;
    end
    error_cnt++;
    give_verdict();
  endtask
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge clk_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= {22'h0, idx, 2'b00};
    hwrite_in <= wr;
    wait_rdy();
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    wait_rdy();
    rd = hrdata_out;
  endtask
  // cycles until the separator output reaches v, bounded
  task automatic wait_sep(input logic v, input int lim);
    for (n = 0; n < lim && sep_vsync_out !== v; n++) @(posedge clk_in);
    chk("sep_vsync", {31'h0, v}, {31'h0, sep_vsync_out});
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    chk("hready_rst", 32'h0, {31'h0, hreadyout_out});
    rst_in <= 1'b0;
    bus(1'b0, IDX_TRIG, 32'h0);
    chk("trig_rst", 32'h40, rd);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    foreach (rows[i]) begin
      bus(1'b1, IDX_SYNC_A, {24'h0, rows[i].a});
      bus(1'b1, IDX_SYNC_B, {24'h0, rows[i].b});
      {hsync_in, lvl, coast_in, vsync_in} <= rows[i].inp;
      repeat (4) @(posedge clk_in);
      chk("mux", {28'h0, rows[i].exp},
        {28'h0, hsync_out, pll_ref_out, pll_hold_out, vsync_out});
    end
    // enable low must hold hsync, ref, hold and vsync outputs where they stood
    ce_in <= 1'b0;
    hsync_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk("ce_freeze", {28'h0, rows[3].exp},
      {28'h0, hsync_out, pll_ref_out, pll_hold_out, vsync_out});
    ce_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk("ce_resume", 32'h1, {31'h0, hsync_out});
    hsync_in <= 1'b0;
    lvl <= 1'b0;
    bus(1'b1, IDX_TRIG, 32'h4);
    bus(1'b1, IDX_SYNC_A, 32'h9);
    bus(1'b0, IDX_TRIG, 32'h0);
    chk("trig", 32'h4, rd);
    go <= 1'b1;
    // short line pulses: 2 steps each, below the trigger
    repeat (3000) @(posedge clk_in);
    chk("short_rej", 32'h0, {31'h0, sep_vsync_out});
    bus(1'b0, IDX_STAT, 32'h0);
    chk("short_cnt", 32'h1, {31'h0, rd[15:8] <= 8'h04});
    go <= 1'b0;
    repeat (2) begin
      wait_sep(1'b0, 300);
      lvl <= 1'b1;
      wait_sep(1'b1, 400);
      chk("det_time", 32'h1, {31'h0, n >= 80 && n <= 170});
      chk("mux4_sep", 32'h1, {31'h0, vsync_out});
      lvl <= 1'b0;
      repeat (40) @(posedge clk_in);
      lvl <= 1'b1;
      repeat (100) @(posedge clk_in);
      chk("serration", 32'h1, {31'h0, sep_vsync_out});
      lvl <= 1'b0;
      wait_sep(1'b0, 400);
      chk("rel_time", 32'h1, {31'h0, n >= 60 && n <= 170});
    end
    bus(1'b1, IDX_TRIG, 32'hff);
    // low-active polarity turns the idle-low line into a long pulse
    bus(1'b1, IDX_POL, 32'h0);
    bus(1'b0, IDX_POL, 32'h0);
    chk("pol", 32'h0, rd);
    repeat (200) @(posedge clk_in);
    bus(1'b0, IDX_STAT, 32'h0);
    chk("pol_low", 32'h1, {31'h0, rd[15:8] != 8'h00});
    bus(1'b1, IDX_POL, 32'h1);
    lvl <= 1'b1;
    repeat (6000) @(posedge clk_in);
    bus(1'b0, IDX_STAT, 32'h0);
    chk("sat_cnt", 32'hff, {24'h0, rd[15:8]});
    chk("no_det", 32'h0, {31'h0, rd[0]});
    lvl <= 1'b0;
    repeat (6000) @(posedge clk_in);
    bus(1'b0, IDX_STAT, 32'h0);
    chk("floor_cnt", 32'h0, {24'h0, rd[15:8]});
    give_verdict();
  end
endmodule
